// ===== design/port_power_ctrl.sv
// power-state controller for a dual usb port power switch
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - below supply threshold: off, nothing kept
// - sleep keeps registers and answers bus
// - error wins; faults latched per port
// - a port fault opens only its own port; thermal high and source overvoltage open both
// - active when faultless and one enabled
// - active closes enabled ports only
// - drain disabled port if auto bit set
// - sleep only with both requests inactive
// - sleep opens switches, releases fault outputs
// - sleep accepts any access width; any access is answered in sleep, writes need byte lane 0 as in every state
// - first sleep read of wake port wakes, returns zero
// - bus-woken device resleeps after idle interval
// - entering active closes enabled switches
// - source undervolt or no request blocks active
// - thermal high limit forces error
// - low limit plus stress forces error
// - listed electrical faults force error
// - error opens switch, asserts fault output
// - auto-recovery retries after one period
// - requests dropping in error: no sleep
// - after fault, sleep needs toggle or read; with drain bit set, recovery allows sleep directly
// - request is pin or soft bit
// - ignore bit drops the pins
module port_power_ctrl
  import port_power_pkg::*;
#(
  parameter int RETRY_CYCLES = port_power_pkg::RETRY_CYC, // retry wait
  parameter int IDLE_CYCLES = port_power_pkg::IDLE_CYC // idle-sleep wait
) (
  input wire logic i_ref_clk, // core clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_core_ok, // core supply above threshold
  input wire logic i_source_ok, // source above undervolt level
  input wire logic i_port1_switch_request, // request pin 1 (async)
  input wire logic i_port2_switch_request, // request pin 2 (async)
  input wire logic i_thermal_high, // high limit exceeded
  input wire logic i_thermal_low, // low limit exceeded
  input wire logic [1:0] i_cc_limit, // port in constant current
  input wire logic [1:0] i_elec_fault, // oc/uv/bv/drain per port
  input wire logic i_source_ov, // source overvoltage
  input wire logic [3:0] i_avs_address, // avalon byte address
  input wire logic i_avs_read, // avalon read
  input wire logic i_avs_write, // avalon write
  input wire logic [31:0] i_avs_writedata, // avalon write data
  input wire logic [3:0] i_avs_byteenable, // avalon byte lanes
  output logic [31:0] o_avs_readdata, // avalon read data
  output logic o_avs_waitrequest, // avalon wait
  output logic [1:0] o_switch_on, // port switch closed
  output logic [1:0] o_drain_on, // port discharge active
  output logic [1:0] o_fault_oe, // fault pin pulled low
  output logic [1:0] o_power_state // current power state
);
  import port_power_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    power_state_t st; // power state
    logic [4:0] cfg; // config register
    logic [1:0] host_drain; // host-driven drain
    logic [1:0] flt; // sticky per-port faults
    logic [1:0] fault_act; // port in fault handling
    logic awake; // woken by bus
    logic post_fault; // left error, no auto sleep
    logic [1:0] req_prev; // previous requests
    logic pwr_up; // first decision after power up
    logic [1:0] s1; // pin sync stage 1
    logic [1:0] s2; // pin sync stage 2
    logic [31:0] retry_cnt; // retry timer
    logic [31:0] idle_cnt; // idle timer
    logic ack; // bus answer pending
    logic [31:0] rdata; // read data
    logic [1:0] sw; // switches
  } ctrl_state_t;

  ctrl_state_t s_reg, s_next;
  logic [1:0] req; // combined requests
  logic [1:0] port_err; // per-port error condition
  logic any_err; // any error condition
  logic req_rise; // a request rose
  logic acc; // bus access this cycle
  logic wake_read; // read of wake port while asleep

  // ****************************************
  // condition decode
  // ****************************************
  // status word of state, sticky faults and awake flag, used for register reads
  function automatic logic [31:0] status_word(input ctrl_state_t s);
    status_word = 32'h0;
    status_word[ST_STATE+:2] = s.st;
    status_word[ST_FAULT1] = s.flt[0];
    status_word[ST_FAULT2] = s.flt[1];
    status_word[ST_AWAKE] = s.awake;
  endfunction

  always_comb begin
    req[0] = s_reg.cfg[CFG_SOFT1] |
      (s_reg.s2[0] & ~s_reg.cfg[CFG_IGNORE]);
    req[1] = s_reg.cfg[CFG_SOFT2] |
      (s_reg.s2[1] & ~s_reg.cfg[CFG_IGNORE]);
    req_rise = |(req & ~s_reg.req_prev);
    // error causes; thermal high and source overvoltage hit both ports
    for (int i = 0; i < 2; i++) begin
      port_err[i] = i_elec_fault[i] | i_thermal_high | i_source_ov |
        (i_thermal_low & (i_cc_limit[i] | req_rise |
        (s_reg.pwr_up & (s_reg.s2 != 2'b00))));
    end
    any_err = |port_err;
    acc = i_avs_read | i_avs_write;
    wake_read = i_avs_read & (i_avs_address == ADDR_WAKE) &
      (s_reg.st == ST_SLEEP) & ~s_reg.awake;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // two flops on the async pins before any decode
    s_next.s1 = {i_port2_switch_request, i_port1_switch_request};
    s_next.s2 = s_reg.s1;
    s_next.req_prev = req;
    s_next.ack = 1'b0;
    s_next.pwr_up = 1'b0;
    // write lands early; the master holds its request anyway
    // bus slave: one wait cycle, answer on the second
    if (acc && !s_reg.ack) begin
      s_next.ack = 1'b1;
      s_next.idle_cnt = 32'h0;
      s_next.rdata = 32'h0;
      if (i_avs_read) begin
        case (i_avs_address)
          ADDR_CONFIG: s_next.rdata = {27'h0, s_reg.cfg};
          ADDR_STATUS: s_next.rdata = status_word(s_reg);
          ADDR_DRAIN: s_next.rdata = {30'h0, s_reg.host_drain};
          // dummy byte reads zero while asleep and not yet woken
          ADDR_WAKE: s_next.rdata = wake_read ? 32'h0 :
            status_word(s_reg);
          default: s_next.rdata = 32'h0;
        endcase
        if (wake_read) begin
          s_next.awake = 1'b1;
        end
        // a register read releases post-fault hold
        s_next.post_fault = 1'b0;
      end else if (i_avs_byteenable[0]) begin
        // only low byte lane is honoured
        case (i_avs_address)
          ADDR_CONFIG: s_next.cfg = i_avs_writedata[4:0];
          ADDR_DRAIN: s_next.host_drain = i_avs_writedata[1:0];
          ADDR_STATUS: s_next.flt = s_reg.flt & ~i_avs_writedata[3:2];
          default: s_next.cfg = s_reg.cfg;
        endcase
      end
    end
    if (s_reg.awake && !acc) begin
      if (s_reg.idle_cnt >= 32'(IDLE_CYCLES - 1)) begin
        s_next.awake = 1'b0;
        s_next.idle_cnt = 32'h0;
      end else begin
        s_next.idle_cnt = s_reg.idle_cnt + 32'h1;
      end
    end
    // latch faults; set beats the clear above
    s_next.flt = s_next.flt | port_err;
    case (s_reg.st)
      ST_OFF: begin
        // leave off with defaults in place
        s_next.st = ST_SLEEP;
        s_next.pwr_up = 1'b1;
      end
      ST_SLEEP: begin
        if (any_err && (req != 2'b00)) begin
          s_next.st = ST_ERR;
          s_next.fault_act = port_err;
          s_next.retry_cnt = 32'h0;
        end else if (i_source_ok && (req != 2'b00)) begin
          s_next.st = ST_ACT;
        end
      end
      ST_ACT: begin
        if (any_err) begin
          s_next.st = ST_ERR;
          s_next.fault_act = port_err;
          s_next.retry_cnt = 32'h0;
        // both inactive: sleep unless post-fault hold; source low alone stays active
        end else if (req == 2'b00 || !i_source_ok) begin
          s_next.st = (req == 2'b00 && !s_reg.post_fault) ?
            ST_SLEEP : ST_ACT;
        end
      end
      ST_ERR: begin
        // requests dropping here do not sleep
        s_next.fault_act = s_reg.fault_act | port_err;
        // without retry the error holds until power loss
        // wait one period, then check
        if (s_reg.cfg[CFG_RETRY]) begin
          if (s_reg.retry_cnt >= 32'(RETRY_CYCLES - 1)) begin
            s_next.retry_cnt = 32'h0;
            if (!any_err) begin
              s_next.st = ST_ACT;
              s_next.fault_act = 2'b00;
              // no automatic sleep without drain bit
              s_next.post_fault = ~s_reg.cfg[CFG_DRAIN];
            end
          end else begin
            s_next.retry_cnt = s_reg.retry_cnt + 32'h1;
          end
        end
      end
      default: s_next.st = ST_OFF;
    endcase
    if (req_rise) begin
      s_next.post_fault = 1'b0;
    end
    // switch targets from the next state
    case (s_next.st)
      ST_ACT: s_next.sw = i_source_ok ? req : 2'b00;
      ST_ERR: s_next.sw = req & ~s_next.fault_act;
      default: s_next.sw = 2'b00;
    endcase
    // supply low: off, all state lost
    if (!i_core_ok) begin
      s_next = '0;
      s_next.cfg = CFG_RESET;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      // config comes back to its default
      s_reg <= '0;
      s_reg.cfg <= CFG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    // combinational wait: the first cycle of a request stalls
    o_avs_waitrequest = acc & ~s_reg.ack;
    o_avs_readdata = s_reg.rdata;
    o_switch_on = s_reg.sw;
    o_power_state = s_reg.st;
    // fault output only in error, per port
    o_fault_oe = (s_reg.st == ST_ERR) ? s_reg.fault_act : 2'b00;
    // drain off ports, auto or by host
    o_drain_on = (s_reg.st == ST_OFF) ? 2'b00 : (~s_reg.sw &
      (s_reg.cfg[CFG_DRAIN] ? 2'b11 : s_reg.host_drain));
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_low_core;
    !i_core_ok;
  endsequence

  property p_off_on_low;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_low_core |=> (o_power_state == ST_OFF) && (o_switch_on == 2'b00);
  endproperty
  a_off_on_low: assert property (p_off_on_low)
    else $error("core low but not off");

  property p_sleep_keeps;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.st == ST_SLEEP) && !i_avs_write && i_core_ok
        |=> s_reg.cfg == $past(s_reg.cfg);
  endproperty
  a_sleep_keeps: assert property (p_sleep_keeps)
    else $error("config lost in sleep");

  property p_err_first;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.st == ST_ACT) && any_err && i_core_ok
        |=> o_power_state == ST_ERR;
  endproperty
  a_err_first: assert property (p_err_first)
    else $error("fault did not enter error");

  property p_sleep_open;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_power_state == ST_SLEEP |-> o_switch_on == 2'b00 &&
        o_fault_oe == 2'b00;
  endproperty
  a_sleep_open: assert property (p_sleep_open)
    else $error("switch or fault in sleep");

  property p_wake_zero;
    @(posedge i_ref_clk) disable iff (i_rst)
      wake_read && !s_reg.ack |=> o_avs_readdata == 32'h0 && s_reg.awake;
  endproperty
  a_wake_zero: assert property (p_wake_zero)
    else $error("wake read not zero");

  property p_err_open;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_power_state == ST_ERR |-> (o_switch_on & o_fault_oe) == 2'b00;
  endproperty
  a_err_open: assert property (p_err_open)
    else $error("faulted port switch closed");

  property p_no_sleep_err;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.st == ST_ERR) && i_core_ok |=> o_power_state != ST_SLEEP;
  endproperty
  a_no_sleep_err: assert property (p_no_sleep_err)
    else $error("error went to sleep");

  property p_act_close;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_power_state == ST_ACT && $past(i_source_ok)
        |-> o_switch_on == $past(req);
  endproperty
  a_act_close: assert property (p_act_close)
    else $error("active switch mismatch");

  // a live request keeps the device out of sleep
  property p_act_stays;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.st == ST_ACT) && (req != 2'b00) && i_core_ok
        |=> o_power_state != ST_SLEEP;
  endproperty
  a_act_stays: assert property (p_act_stays)
    else $error("sleep with a request active");

  // low source or no request blocks the way from sleep to active
  property p_sleep_blocked;
    @(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.st == ST_SLEEP) && (!i_source_ok || (req == 2'b00))
        |=> o_power_state != ST_ACT;
  endproperty
  a_sleep_blocked: assert property (p_sleep_blocked)
    else $error("active while blocked");

  // wake flag drops once the idle interval runs out
  property p_idle_sleep;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_reg.awake && !acc && i_core_ok &&
        (s_reg.idle_cnt == 32'(IDLE_CYCLES - 1)) |=> !s_reg.awake;
  endproperty
  a_idle_sleep: assert property (p_idle_sleep)
    else $error("awake after idle interval");

  // auto drain pulls every open port in active
  property p_auto_drain;
    @(posedge i_ref_clk) disable iff (i_rst)
      (o_power_state == ST_ACT) && s_reg.cfg[CFG_DRAIN]
        |-> o_drain_on == ~o_switch_on;
  endproperty
  a_auto_drain: assert property (p_auto_drain)
    else $error("open port not drained");

endmodule
`default_nettype wire

// ===== design/port_power_pkg.sv
// constants for the dual-port power-state controller
package port_power_pkg;

  // ****************************************
  // register map (byte addresses, word aligned)
  // ****************************************
  localparam logic [3:0] ADDR_CONFIG = 4'h0; // soft requests and options
  localparam logic [3:0] ADDR_STATUS = 4'h4; // state and sticky faults
  localparam logic [3:0] ADDR_DRAIN = 4'h8; // host drain control
  localparam logic [3:0] ADDR_WAKE = 4'hC; // single-byte wake/read port

  // config field positions
  localparam int CFG_SOFT1 = 0; // port 1 soft request
  localparam int CFG_SOFT2 = 1; // port 2 soft request
  localparam int CFG_IGNORE = 2; // ignore request pins
  localparam int CFG_DRAIN = 3; // auto port drain
  localparam int CFG_RETRY = 4; // auto-recovery enable
  localparam logic [4:0] CFG_RESET = 5'h10; // auto-recovery on

  // status field positions
  localparam int ST_STATE = 0; // two-bit power state
  localparam int ST_FAULT1 = 2; // sticky fault port 1
  localparam int ST_FAULT2 = 3; // sticky fault port 2
  localparam int ST_AWAKE = 4; // woken by bus

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100; // core clock rate
  localparam int RETRY_US = 20000; // retry period in microseconds
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
  localparam int IDLE_US = 50000; // idle-sleep interval in microseconds
  localparam int IDLE_CYC = IDLE_US * CLK_MHZ;

  // ****************************************
  // power states
  // ****************************************
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_SLEEP = 2'b01,
    ST_ACT = 2'b10,
    ST_ERR = 2'b11
  } power_state_t;

endpackage

// ===== testbench/host_pins.sv
// host-side model: request pins and pulled-up fault lines
`timescale 1ns/1ps
`default_nettype none
module host_pins (
  input wire logic [1:0] i_want, // bench request, set at an edge
  input wire logic [1:0] i_fault_oe, // device pulls fault line low
  output logic [1:0] o_req, // request pins to the device
  output logic [1:0] o_alert_n // fault line level seen by host
);
  assign o_req = i_want;
  assign o_alert_n = ~i_fault_oe;
endmodule
`default_nettype wire

// ===== testbench/test_port_power_ctrl.sv
// self-checking bench for the power-state controller
`timescale 1ns/1ps
`default_nettype none
module test_port_power_ctrl;
  import port_power_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int RETRY = 16; // shortened retry period
  localparam int IDLE = 32; // shortened idle interval
  logic clk = 0, rst = 1, core_ok = 1, src_ok = 1;
  logic t_hi = 0, t_lo = 0, s_ov = 0, rd = 0, wr = 0, wait_req;
  logic [1:0] cc = 0, ef = 0, want = 0, req, alert_n, sw, dr, oe, st;
  logic [1:0] e, eff; // expected masks
  logic [3:0] addr = 0, be = 4'hF;
  logic [31:0] wd = 0, rdat, q, r;
  int err_total = 0, comparisons = 0, cycles = 0, seed = 44;
  always #5 clk = ~clk;
  port_power_ctrl #(.RETRY_CYCLES(RETRY), .IDLE_CYCLES(IDLE))
    port_power_ctrl_inst (.i_ref_clk(clk), .i_rst(rst), .i_core_ok(core_ok),
    .i_source_ok(src_ok), .i_port1_switch_request(req[0]),
    .i_port2_switch_request(req[1]), .i_thermal_high(t_hi),
    .i_thermal_low(t_lo), .i_cc_limit(cc), .i_elec_fault(ef),
    .i_source_ov(s_ov), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wait_req), .o_switch_on(sw),
    .o_drain_on(dr), .o_fault_oe(oe), .o_power_state(st));
  host_pins host_pins_inst (.i_want(want), .i_fault_oe(oe), .o_req(req),
    .o_alert_n(alert_n));
  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input string n, input logic [31:0] x,
                         input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_out(input string n, input logic [1:0] x,
                         input logic [1:0] g);
    chk_reg(n, 32'(x), 32'(g));
  endtask
  // expected request per port from pins and config bits
  function automatic logic [1:0] exp_req(input logic [1:0] pins,
                                         input logic [3:0] c);
    exp_req = (c[2] ? 2'b00 : pins) | c[1:0];
  endfunction
  // expected drain: open ports, auto or by host
  function automatic logic [1:0] exp_drain(input logic [1:0] on,
                                           input logic au,
                                           input logic [1:0] h);
    exp_drain = ~on & (au ? 2'b11 : h);
  endfunction
  // wait n edges, then settle to the falling edge for sampling
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // one bus cycle held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    be <= b;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge clk);
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    wt(3);
    chk_out("state", ST_OFF, st);
    @(posedge clk);
    rst <= 0;
    wt(3);
    chk_out("state", ST_SLEEP, st);
    // dummy wake byte, checked by the bench to read zero
    bus(0, ADDR_WAKE, 0, 4'hF);
    chk_reg("wake", 0, q);
    bus(0, ADDR_WAKE, 0, 4'hF);
    chk_reg("awake", 32'h10, q & 32'h10);
    bus(1, ADDR_CONFIG, 32'h3, 4'hE);
    bus(0, ADDR_CONFIG, 0, 4'hF);
    chk_reg("config", 32'h10, q);
    wt(IDLE + 8);
    bus(0, ADDR_WAKE, 0, 4'hF);
    chk_reg("rewake", 0, q);
    bus(1, ADDR_CONFIG, 32'h13, 4'hF);
    wt(4);
    chk_out("switch", 2'b11, sw);
    @(posedge clk);
    t_lo <= 1;
    wt(4);
    chk_out("state", ST_ACT, st);
    // one fault kind per pass, then auto-recovery
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      t_hi <= (k == 0);
      t_lo <= (k == 1);
      cc <= {1'b0, k == 1};
      s_ov <= (k == 2);
      ef <= {1'b0, k == 3};
      // low limit with current limit hits that port only
      e = (k == 1 || k == 3) ? 2'b01 : 2'b11;
      wt(4);
      chk_out("state", ST_ERR, st);
      chk_out("switch", ~e, sw);
      chk_out("alert_n", ~e, alert_n);
      bus(0, ADDR_STATUS, 0, 4'hF);
      chk_reg("faults", 32'(e), 32'(q[3:2]));
      @(posedge clk);
      t_hi <= 0;
      t_lo <= 0;
      s_ov <= 0;
      cc <= 0;
      ef <= 0;
      bus(1, ADDR_STATUS, 32'hC, 4'hF);
      wt(RETRY + 8);
      chk_out("state", ST_ACT, st);
    end
    @(posedge clk);
    src_ok <= 0;
    wt(4);
    chk_out("switch", 2'b00, sw);
    @(posedge clk);
    src_ok <= 1;
    ef <= 2'b10;
    wt(4);
    bus(1, ADDR_CONFIG, 32'h10, 4'hF);
    wt(4);
    chk_out("state", ST_ERR, st);
    @(posedge clk);
    ef <= 0;
    bus(1, ADDR_STATUS, 32'hC, 4'hF);
    wt(RETRY + 8);
    chk_out("no_sleep", 2'b00, {1'b0, st === ST_SLEEP});
    bus(0, ADDR_STATUS, 0, 4'hF);
    wt(4);
    chk_out("state", ST_SLEEP, st);
    chk_out("alert_n", 2'b11, alert_n);
    // random pins, soft bits, ignore and drain options
    repeat (12) begin
      r = $random(seed);
      @(posedge clk);
      want <= r[1:0];
      bus(1, ADDR_CONFIG, {27'h0, 1'b1, r[5:2]}, 4'hF);
      bus(1, ADDR_DRAIN, {30'h0, r[7:6]}, 4'hF);
      wt(6);
      eff = exp_req(r[1:0], r[5:2]);
      chk_out("switch", eff, sw);
      chk_out("state", (eff != 0) ? ST_ACT : ST_SLEEP, st);
      chk_out("drain", exp_drain(eff, r[5], r[7:6]), dr);
    end
    // retry off: the error state holds after faults clear
    @(posedge clk);
    want <= 2'b00;
    bus(1, ADDR_CONFIG, 32'h1, 4'hF);
    wt(4);
    chk_out("state", ST_ACT, st);
    @(posedge clk);
    ef <= 2'b01;
    wt(4);
    @(posedge clk);
    ef <= 2'b00;
    wt(RETRY + 8);
    chk_out("state", ST_ERR, st);
    @(posedge clk);
    core_ok <= 0;
    wt(2);
    chk_out("state", ST_OFF, st);
    chk_out("switch", 2'b00, sw);
    @(posedge clk);
    core_ok <= 1;
    want <= 0;
    wt(3);
    bus(0, ADDR_CONFIG, 0, 4'hF);
    chk_reg("config", 32'(CFG_RESET), q);
    results();
  end
endmodule
`default_nettype wire
